// [src/idcr_regs.sv]
`timescale 1ns/100ps

module idcr_regs import idcr_pkg::*; (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              pclk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire idcr_fmt_e         img_fmt,
    input  wire logic              block_mode,
    output idcr_cfg_s              cfg,
    output idcr_buf_s              buf_sel,
    output logic                   dec_tick,
    output logic                   flash_tick
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [7:0]        idx;
    logic [3:0]        off;
    logic              hit;
    logic              setup;
    logic              wr_fire;
    logic [REG_W-1:0]  regs_r [NUM_REGS];
    logic [REG_W-1:0]  rd_byte;
    logic [REG_W-1:0]  status;
    logic              pready_r;
    logic [DATA_W-1:0] prdata_r;
    logic              pslverr_r;
    logic              wr_ok_r;
    logic [3:0]        wr_off_r;
    logic              tick_r;
    logic              slow;
    logic              still;
    idcr_cfg_s         cfg_r;
    idcr_buf_s         buf_r;

    assign idx   = paddr[9:2];
    assign off   = 4'(idx - IDX_BASE);
    assign hit   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && (idx >= IDX_BASE) && (idx <= IDX_LAST);
    assign setup = psel && !penable;

    // write lands only on the access edge that completes the transfer
    assign wr_fire = psel && penable && pready_r && pwrite && wr_ok_r && pstrb[0];

    // no wait state: everything is decided in setup and held into access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else if (pclk_en) begin
            pready_r <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
            wr_ok_r   <= 1'b0;
            wr_off_r  <= 4'h0;
        end else if (pclk_en) begin
            pslverr_r <= setup && !hit;
            wr_ok_r   <= setup && hit;
            wr_off_r  <= off;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    // status slot has a zero write mask, so its flop stays at reset
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    regs_r[g] <= REG_RST;
                end else if (pclk_en && wr_fire && (wr_off_r == 4'(g))) begin
                    regs_r[g] <= pwdata[REG_W-1:0] & reg_wmask(8'(IDX_BASE + 8'(g)));
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // status and read data
    // ------------------------------------------------------------------
    // too-slow check is a help to software; the setting remains its duty
    always_comb begin
        slow = 1'b0;
        case (regs_r[0][1:0])
            DIV_BY1: slow = (CORE_CLK_HZ <= MIN_DEC_HZ);
            DIV_BY2: slow = ((CORE_CLK_HZ / 2) <= MIN_DEC_HZ);
            DIV_BY4: slow = ((CORE_CLK_HZ / 4) <= MIN_DEC_HZ);
            default: slow = 1'b1;
        endcase
    end

    always_comb begin
        status = REG_RST;
        status[ST_RSVD_BIT] = (regs_r[0][1:0] == DIV_RSVD);
        status[ST_SLOW_BIT] = slow;
        status[ST_TICK_BIT] = tick_r;
    end

    always_comb begin
        rd_byte = REG_RST;
        if (hit && (idx == IDX_STATUS)) begin
            rd_byte = status;
        end else if (hit) begin
            rd_byte = regs_r[off];
        end
    end

    // unmapped reads return zero alongside pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (pclk_en) begin
            prdata_r <= (setup && !pwrite) ? {24'h000000, rd_byte} : '0;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // decoder clock
    // ------------------------------------------------------------------
    idcr_clk_div u_clk_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (pclk_en),
        .div_code (regs_r[0][1:0]),
        .tick_r   (tick_r)
    );

    // one flop feeds both loads so they never drift apart
    assign dec_tick   = tick_r;
    assign flash_tick = tick_r;

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    assign still = block_mode && ((img_fmt == IDCR_FMT_JPG) || (img_fmt == IDCR_FMT_BMP));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r.src_addr   <= '0;
            cfg_r.xfer_count <= '0;
        end else if (pclk_en) begin
            cfg_r.src_addr   <= {regs_r[4], regs_r[3], regs_r[2], regs_r[1]};
            cfg_r.xfer_count <= {regs_r[14], regs_r[13], regs_r[12], regs_r[11]};
        end
    end

    // corner forced to zero outside still block mode, AVI ignores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r.dest_x <= '0;
            cfg_r.dest_y <= '0;
        end else if (pclk_en) begin
            if (still) begin
                cfg_r.dest_x <= {regs_r[6][COORD_HI_W-1:0], regs_r[5]};
                cfg_r.dest_y <= {regs_r[8][COORD_HI_W-1:0], regs_r[7]};
            end else begin
                cfg_r.dest_x <= '0;
                cfg_r.dest_y <= '0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_r <= '{ovl_one: 1'b1, ovl_two: 1'b0, shadow: 1'b1};
        end else if (pclk_en) begin
            case (regs_r[10][1:0])
                BUF_OVL1_SHADOW: buf_r <= '{ovl_one: 1'b1, ovl_two: 1'b0, shadow: 1'b1};
                BUF_OVL2_SHADOW: buf_r <= '{ovl_one: 1'b0, ovl_two: 1'b1, shadow: 1'b1};
                default:         buf_r <= '{ovl_one: 1'b1, ovl_two: 1'b0, shadow: 1'b0};
            endcase
        end
    end

    assign cfg     = cfg_r;
    assign buf_sel = buf_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_ready;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        setup |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not a single access cycle");

    property p_shared_tick;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (presetn && (regs_r[0][1:0] == DIV_BY1))[*2] |-> dec_tick && flash_tick;
    endproperty
    a_shared_tick: assert property (p_shared_tick) else $error("decoder and flash ticks disagree");

    property p_src_hi;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (wr_fire && wr_off_r == 4'(IDX_SRC3 - IDX_BASE)) ##1 pclk_en
        |=> cfg.src_addr[31:24] == $past(pwdata[7:0], 2);
    endproperty
    a_src_hi: assert property (p_src_hi) else $error("source address top byte not applied");

    property p_src_lo;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (wr_fire && wr_off_r == 4'(IDX_SRC0 - IDX_BASE)) ##1 pclk_en
        |=> cfg.src_addr[7:0] == $past(pwdata[7:0], 2);
    endproperty
    a_src_lo: assert property (p_src_lo) else $error("source address low byte not applied");

    property p_dx;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        still |=> cfg.dest_x == {$past(regs_r[6][4:0]), $past(regs_r[5])};
    endproperty
    a_dx: assert property (p_dx) else $error("corner x not 13 bits from two registers");

    property p_dy;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (wr_fire && wr_off_r == 4'(IDX_DY_HI - IDX_BASE)) ##1 (pclk_en && still)
        |=> cfg.dest_y[12:8] == $past(pwdata[4:0], 2);
    endproperty
    a_dy: assert property (p_dy) else $error("corner y high bits not applied");

    property p_avi_zero;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (img_fmt == IDCR_FMT_AVI) |=> (cfg.dest_x == '0) && (cfg.dest_y == '0);
    endproperty
    a_avi_zero: assert property (p_avi_zero) else $error("corner applied during video");

    property p_buf;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        regs_r[10][1] |=> buf_sel.ovl_one && !buf_sel.ovl_two && !buf_sel.shadow;
    endproperty
    a_buf: assert property (p_buf) else $error("code 1x must use overlay one alone");

    property p_tf0;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (wr_fire && wr_off_r == 4'(IDX_TF0 - IDX_BASE)) ##1 pclk_en
        |=> cfg.xfer_count[7:0] == $past(pwdata[7:0], 2);
    endproperty
    a_tf0: assert property (p_tf0) else $error("transfer count low byte not applied");

    property p_tf3;
        @(posedge pclk) disable iff (!presetn || !pclk_en)
        (wr_fire && wr_off_r == 4'(IDX_TF3 - IDX_BASE)) ##1 pclk_en
        |=> cfg.xfer_count[31:24] == $past(pwdata[7:0], 2);
    endproperty
    a_tf3: assert property (p_tf3) else $error("transfer count top byte not applied");

    c_wr_tf0: cover property (@(posedge pclk) disable iff (!presetn)
        wr_fire && wr_off_r == 4'(IDX_TF0 - IDX_BASE));
    c_rd_status: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == IDX_STATUS);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
    c_still: cover property (@(posedge pclk) disable iff (!presetn) still ##1 cfg.dest_x != '0);

endmodule : idcr_regs

// [pkg/idcr_pkg.sv]
package idcr_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned NUM_REGS = 15;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_BASE    = 8'hBB;
    localparam logic [7:0] IDX_CLK_DIV = 8'hBB;
    localparam logic [7:0] IDX_SRC0    = 8'hBC;
    localparam logic [7:0] IDX_SRC1    = 8'hBD;
    localparam logic [7:0] IDX_SRC2    = 8'hBE;
    localparam logic [7:0] IDX_SRC3    = 8'hBF;
    localparam logic [7:0] IDX_DX_LO   = 8'hC0;
    localparam logic [7:0] IDX_DX_HI   = 8'hC1;
    localparam logic [7:0] IDX_DY_LO   = 8'hC2;
    localparam logic [7:0] IDX_DY_HI   = 8'hC3;
    localparam logic [7:0] IDX_STATUS  = 8'hC4;
    localparam logic [7:0] IDX_BUF_SEL = 8'hC5;
    localparam logic [7:0] IDX_TF0     = 8'hC6;
    localparam logic [7:0] IDX_TF1     = 8'hC7;
    localparam logic [7:0] IDX_TF2     = 8'hC8;
    localparam logic [7:0] IDX_TF3     = 8'hC9;
    localparam logic [7:0] IDX_LAST    = 8'hC9;

    // ------------------------------------------------------------------
    // reset values, field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [7:0] MASK_FULL    = 8'hFF;
    localparam logic [7:0] MASK_BUF_SEL = 8'h03;
    localparam logic [7:0] MASK_NONE    = 8'h00;
    localparam int unsigned COORD_W     = 13;
    localparam int unsigned COORD_HI_W  = 5;
    localparam int unsigned ST_RSVD_BIT = 0;
    localparam int unsigned ST_SLOW_BIT = 1;
    localparam int unsigned ST_TICK_BIT = 2;

    // ------------------------------------------------------------------
    // divider codes and clock figures
    // ------------------------------------------------------------------
    localparam logic [1:0] DIV_BY1  = 2'h0;
    localparam logic [1:0] DIV_BY2  = 2'h1;
    localparam logic [1:0] DIV_BY4  = 2'h2;
    localparam logic [1:0] DIV_RSVD = 2'h3;
    localparam logic [1:0] BUF_OVL1_SHADOW = 2'h0;
    localparam logic [1:0] BUF_OVL2_SHADOW = 2'h1;
    localparam longint unsigned CORE_CLK_HZ  = 100_000_000;
    localparam longint unsigned XOSC_HZ      = 10_000_000;
    localparam longint unsigned MIN_RATIO    = 2;
    localparam longint unsigned MIN_DEC_HZ   = MIN_RATIO * XOSC_HZ;

    typedef enum logic [1:0] {IDCR_FMT_AVI, IDCR_FMT_JPG, IDCR_FMT_BMP, IDCR_FMT_NONE} idcr_fmt_e;

    typedef struct packed {
        logic [31:0]        src_addr;
        logic [31:0]        xfer_count;
        logic [COORD_W-1:0] dest_x;
        logic [COORD_W-1:0] dest_y;
    } idcr_cfg_s;

    typedef struct packed {
        logic ovl_one;
        logic ovl_two;
        logic shadow;
    } idcr_buf_s;

    function automatic logic [7:0] reg_wmask(input logic [7:0] idx);
        logic [7:0] m;
        m = MASK_FULL;
        if (idx == IDX_STATUS) begin
            m = MASK_NONE;
        end else if (idx == IDX_BUF_SEL) begin
            m = MASK_BUF_SEL;
        end
        return m;
    endfunction : reg_wmask

endpackage : idcr_pkg

// [src/idcr_clk_div.sv]
`timescale 1ns/100ps

module idcr_clk_div import idcr_pkg::*; (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    input  wire logic [1:0] div_code,
    output logic            tick_r
);

    logic [1:0] cnt_r;
    logic [1:0] code_q_r;

    // restart phase on a code change so the first period is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r    <= 2'h0;
            code_q_r <= DIV_BY1;
        end else if (clk_en) begin
            code_q_r <= div_code;
            cnt_r    <= (div_code != code_q_r) ? 2'h0 : cnt_r + 2'h1;
        end
    end

    // reserved code stops the decoder clock rather than guess a rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_r <= 1'b0;
        end else if (clk_en) begin
            case (div_code)
                DIV_BY1: tick_r <= 1'b1;
                DIV_BY2: tick_r <= (div_code == code_q_r) & cnt_r[0];
                DIV_BY4: tick_r <= (div_code == code_q_r) & (cnt_r == 2'h3);
                default: tick_r <= 1'b0;
            endcase
        end
    end

    property p_div1;
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (presetn && (div_code == DIV_BY1))[*2] |-> tick_r;
    endproperty
    a_div1: assert property (p_div1) else $error("divide by one not every cycle");

    property p_div2;
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (div_code == DIV_BY2)[*4] ##0 tick_r ##1 (div_code == DIV_BY2) |-> !tick_r;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two tick spacing wrong");

    property p_div4;
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (div_code == DIV_BY4)[*4] ##0 tick_r ##1 (div_code == DIV_BY4)[*4]
        |-> tick_r && !$past(tick_r, 1) && !$past(tick_r, 2) && !$past(tick_r, 3);
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four tick spacing wrong");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn || !clk_en)
        (div_code == DIV_RSVD) |=> !tick_r;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code produced a tick");

    c_div4: cover property (@(posedge pclk) disable iff (!presetn)
        (div_code == DIV_BY4) && tick_r);

endmodule : idcr_clk_div

// [dv/idcr_apb_host.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// host side: apb master that programs the registers
// ----------------------------------------------------------------------
module idcr_apb_host import idcr_pkg::*; (
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    output logic      [3:0]        pstrb,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        pstrb   = 4'h0;
    end

    // request held unchanged until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wd,
                        input logic [3:0] strb, output logic [DATA_W-1:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released bus shows no stale value
        paddr   <= ~addr;
        pwdata  <= ~wd;
    endtask : xfer
endmodule : idcr_apb_host

// [dv/idcr_regs_bench.sv]
`timescale 1ns/100ps

module idcr_regs_bench import idcr_pkg::*; ;
    logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, block_mode, dec_tick, flash_tick;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0]        pstrb;
    idcr_fmt_e         img_fmt;
    idcr_cfg_s         cfg;
    idcr_buf_s         buf_sel;
    int                num_errors = 0;
    int                num_checks = 0;
    int                cycles = 0;

    idcr_regs i_dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .img_fmt(img_fmt), .block_mode(block_mode), .cfg(cfg), .buf_sel(buf_sel),
        .dec_tick(dec_tick), .flash_tick(flash_tick));
    idcr_apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            $display("Error at %0t: timeout", $time);
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        // junk in upper bytes must not be stored
        i_host.xfer(1'b1, ba(idx), {24'hA5A5A5, d}, 4'hF, rd, err);
        chk({31'h0, err}, 32'h0, "write error flag");
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        i_host.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
        chk(rd, {24'h0, exp}, "read data");
        chk({31'h0, err}, {31'h0, exp_err}, "read error flag");
    endtask : rd_chk

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = IDX_CLK_DIV; i <= IDX_TF3; i++) begin
            if (i != IDX_STATUS) rd_chk(ba(8'(i)), 8'h00, 1'b0);
        end
        chk({29'h0, buf_sel}, 32'h5, "buffer select at reset");
        chk(32'(cfg.src_addr), 32'h0, "source address at reset");
        $display("reset test done");
    endtask : t_reset

    task automatic t_src();
        wr(IDX_SRC0, 8'h11);
        wr(IDX_SRC1, 8'h22);
        wr(IDX_SRC2, 8'h33);
        wr(IDX_SRC3, 8'h44);
        repeat (3) @(posedge pclk);
        chk(cfg.src_addr, 32'h44332211, "source address");
        rd_chk(ba(IDX_SRC3), 8'h44, 1'b0);
        $display("source address test done");
    endtask : t_src

    task automatic t_count();
        logic [31:0] rd;
        logic        err;
        wr(IDX_TF0, 8'h78);
        wr(IDX_TF1, 8'h56);
        wr(IDX_TF2, 8'h34);
        wr(IDX_TF3, 8'h12);
        // byte lane zero not strobed: write must be dropped
        i_host.xfer(1'b1, ba(IDX_TF0), 32'hEE, 4'hE, rd, err);
        repeat (3) @(posedge pclk);
        chk(cfg.xfer_count, 32'h12345678, "transfer count");
        rd_chk(ba(IDX_TF3), 8'h12, 1'b0);
        rd_chk(ba(IDX_TF0), 8'h78, 1'b0);
        $display("transfer count test done");
    endtask : t_count

    task automatic t_corner();
        wr(IDX_DX_LO, 8'h34);
        wr(IDX_DX_HI, 8'hFF);
        wr(IDX_DY_LO, 8'hCD);
        wr(IDX_DY_HI, 8'h0A);
        for (int k = 0; k < 4; k++) begin
            block_mode <= (k != 3);
            img_fmt    <= (k == 0) ? IDCR_FMT_JPG : (k == 1) ? IDCR_FMT_BMP : (k == 2) ? IDCR_FMT_AVI : IDCR_FMT_JPG;
            repeat (3) @(posedge pclk);
            chk(32'(cfg.dest_x), (k < 2) ? 32'h1F34 : 32'h0, "corner x");
            chk(32'(cfg.dest_y), (k < 2) ? 32'h0ACD : 32'h0, "corner y");
        end
        $display("corner test done");
    endtask : t_corner

    task automatic t_bufsel();
        logic [2:0] exp;
        for (int c = 0; c < 4; c++) begin
            exp = (c == 0) ? 3'b101 : (c == 1) ? 3'b011 : 3'b100;
            wr(IDX_BUF_SEL, {6'h3F, 2'(c)});
            repeat (3) @(posedge pclk);
            chk({29'h0, buf_sel}, {29'h0, exp}, "buffer select");
            rd_chk(ba(IDX_BUF_SEL), {6'h0, 2'(c)}, 1'b0);
        end
        $display("buffer select test done");
    endtask : t_bufsel

    task automatic t_div();
        logic [31:0] rd;
        logic        err;
        int          n;
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CLK_DIV, 8'(c));
            repeat (4) @(posedge pclk);
            n = 0;
            repeat (16) begin
                @(posedge pclk);
                n += (dec_tick === 1'b1);
                chk({31'h0, flash_tick}, {31'h0, dec_tick}, "flash tick");
            end
            chk(32'(n), (c == 3) ? 32'h0 : 32'(16 >> c), "tick count");
            i_host.xfer(1'b0, ba(IDX_STATUS), 32'h0, 4'h0, rd, err);
            chk({31'h0, rd[ST_RSVD_BIT]}, {31'h0, c == 3}, "reserved flag");
            chk({31'h0, rd[ST_SLOW_BIT]}, {31'h0, c == 3}, "slow flag");
        end
        $display("divider test done");
    endtask : t_div

    task automatic t_err();
        rd_chk(12'h000, 8'h00, 1'b1);
        rd_chk(ba(IDX_SRC0) | 12'h001, 8'h00, 1'b1);
        rd_chk(ba(8'hCA), 8'h00, 1'b1);
        $display("unmapped test done");
    endtask : t_err

    initial begin
        presetn    = 1'b0;
        pclk_en    = 1'b1;
        block_mode = 1'b0;
        img_fmt    = IDCR_FMT_NONE;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_src();
        t_count();
        t_corner();
        t_bufsel();
        t_div();
        t_err();
        close_out();
    end
endmodule : idcr_regs_bench
